// ---- logic/cpumcb_top.sv ----
// cpu module clock generation, status latch, data buffer steering and control bus
// Behaviour
// - each cycle: status capture, command, data move, then next status capture
// - control bus separates memory read/write, io read/write, interrupt acknowledge
// - the two processor clock phases never overlap
// - four bit presettable counter on 20 MHz; phases decoded from it
// - advanced phase one clocks synchronisers for hold and ready
// - status strobe is cycle start marker gated with advanced phase one
// - status byte at cycle start is captured in an 8 bit latch
// - latch loads only on the status strobe, once per machine cycle
// - latch reads processor data lines ahead of the buffer
// - four commands from latch gated with data in and write strobes
// - buffer inbound while data in strobe active, outbound otherwise
// - buffer release floats the system side for dma masters
// - single 8 bit three state system data bus
// - interrupt acknowledge from latch gated with data in strobe
// - memory read command gates data during the third state
// - memory write command only once write data is stable
`timescale 1ns/1ps
`include "cpumcb_map.svh"
module cpumcb_top
   import cpumcb_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // processor timing and strobes (pins)
   input wire logic cycle_start,
   input wire logic data_in_strobe,
   input wire logic write_strobe_n,
   // external requests (pins)
   input wire logic hold_req,
   input wire logic ready_req,
   input wire logic buffer_release_n,
   // processor data lines
   input wire logic [7:0] cpu_data_in,
   output logic [7:0] cpu_data_out,
   output logic cpu_data_oe,
   // system data bus
   input wire logic [7:0] sys_data_in,
   output logic [7:0] sys_data_out,
   output logic sys_data_oe,
   // clocks, sync outputs, status and commands
   output cpumcb_clk_t proc_clk,
   output logic status_capture_strobe_n,
   output logic hold_sync,
   output logic ready_sync,
   output logic buffer_direction_select,
   output logic [7:0] status_byte,
   output cpumcb_cmd_t cmd
);
   cpumcb_clk_t clk_w;
   // pin synchronisers: stage one, stage two
   logic [12:0] s1_reg;
   logic [12:0] s2_reg;
   logic [12:0] pin_w;
   logic [7:0] dbuf_reg;
   logic [7:0] dbuf_next;
   logic [7:0] sbuf_reg;
   logic [7:0] sbuf_next;
   logic [7:0] stat_reg;
   logic [7:0] stat_next;
   logic strobe_reg;
   logic strobe_next;
   logic [1:0] req_reg;
   logic [1:0] req_next;
   cpumcb_cmd_t cmd_reg;
   cpumcb_cmd_t cmd_next;
   logic dir_reg;
   logic dir_next;
   logic cpu_oe_reg;
   logic cpu_oe_next;
   logic sys_oe_reg;
   logic sys_oe_next;
   logic sync_w;
   logic din_w;
   logic wr_n_w;
   logic hold_w;
   logic ready_w;
   logic rel_n_w;

   cpumcb_clkgen u_clkgen (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .clk_out(clk_w),
      .tick()
   );

   // two flip-flops on every pin before use
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         s1_reg <= 13'h0000;
         s2_reg <= 13'h0000;
      end else begin
         // order: cycle start, data in, write, hold, ready, release, spare bits
         s1_reg <= {cycle_start, data_in_strobe, ~write_strobe_n, hold_req, ready_req,
            ~buffer_release_n, 7'h00};
         s2_reg <= s1_reg;
      end
   end
   assign pin_w = s2_reg;
   assign sync_w = pin_w[12];
   assign din_w = pin_w[11];
   assign wr_n_w = ~pin_w[10];
   assign hold_w = pin_w[9];
   assign ready_w = pin_w[8];
   assign rel_n_w = ~pin_w[7];

   // data lines take the same two flops as the strobes, so the status byte
   // and the cycle start marker reach the latch in the same cycle
   always_comb begin
      dbuf_next = cpu_data_in;
      sbuf_next = sys_data_in;
   end
   logic [7:0] dbuf2_reg;
   logic [7:0] sbuf2_reg;
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         dbuf_reg <= 8'h00;
         sbuf_reg <= 8'h00;
         dbuf2_reg <= 8'h00;
         sbuf2_reg <= 8'h00;
      end else begin
         dbuf_reg <= dbuf_next;
         sbuf_reg <= sbuf_next;
         dbuf2_reg <= dbuf_reg;
         sbuf2_reg <= sbuf_reg;
      end
   end

   // status strobe, latch and request synchronisers
   always_comb begin
      strobe_next = sync_w && clk_w.advanced_phase_one;
      stat_next = stat_reg;
      if (strobe_next) begin
         stat_next = dbuf2_reg;
      end
      req_next = req_reg;
      if (clk_w.advanced_phase_one) begin
         req_next = {hold_w, ready_w};
      end
   end

   // command gating and buffer steering
   always_comb begin
      // command after the status latch in each cycle, then data moves under it
      cmd_next.memory_read_cmd_n = ~(stat_reg[`CPUMCB_ST_MEMR] && din_w);
      cmd_next.io_read_cmd_n = ~(!stat_reg[`CPUMCB_ST_MEMR] &&
         !stat_reg[`CPUMCB_ST_ACK] && din_w &&
         !stat_reg[`CPUMCB_ST_OUT]);
      cmd_next.memory_write_cmd_n = ~(!wr_n_w && !stat_reg[`CPUMCB_ST_OUT]);
      cmd_next.io_write_cmd_n = ~(!wr_n_w && stat_reg[`CPUMCB_ST_OUT]);
      cmd_next.interrupt_ack_cmd_n = ~(stat_reg[`CPUMCB_ST_ACK] && din_w);
      dir_next = din_w;
      // rel_n_w low means the buffer is released: neither side may be driven then
      cpu_oe_next = din_w && rel_n_w;
      sys_oe_next = !din_w && !wr_n_w && rel_n_w;
   end

   // registers
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         strobe_reg <= 1'b0;
         stat_reg <= 8'h00;
         req_reg <= 2'h0;
         cmd_reg <= '1;
         dir_reg <= 1'b0;
         cpu_oe_reg <= 1'b0;
         sys_oe_reg <= 1'b0;
      end else begin
         strobe_reg <= strobe_next;
         stat_reg <= stat_next;
         req_reg <= req_next;
         cmd_reg <= cmd_next;
         dir_reg <= dir_next;
         cpu_oe_reg <= cpu_oe_next;
         sys_oe_reg <= sys_oe_next;
      end
   end

   // outputs
   assign proc_clk = clk_w;
   assign status_capture_strobe_n = ~strobe_reg;
   assign hold_sync = req_reg[1];
   assign ready_sync = req_reg[0];
   assign buffer_direction_select = dir_reg;
   assign status_byte = stat_reg;
   assign cmd = cmd_reg;
   assign cpu_data_out = sbuf2_reg;
   assign cpu_data_oe = cpu_oe_reg;
   assign sys_data_out = dbuf2_reg;
   assign sys_data_oe = sys_oe_reg;

   // checks
   latch_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !strobe_reg |-> stat_reg == $past(stat_reg)) else $error("latch moved");
   latch_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      strobe_reg |-> stat_reg == $past(dbuf2_reg)) else $error("latch wrong");
   strobe_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      strobe_reg |-> $past(sync_w) && $past(clk_w.advanced_phase_one))
      else $error("bad strobe");
   bus_release_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !$past(rel_n_w) |-> !sys_data_oe && !cpu_data_oe) else $error("bus not freed");
   buffer_dir_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      dir_reg == $past(din_w)) else $error("direction wrong");
   one_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !(sys_data_oe && cpu_data_oe)) else $error("both sides driven");
   ack_cmd_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !cmd.interrupt_ack_cmd_n |-> $past(din_w)) else $error("ack without data in strobe");
   write_cmd_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !cmd.memory_write_cmd_n |-> !$past(wr_n_w)) else $error("write early");
   one_cmd_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $countones(~{cmd}) <= 1) else $error("two commands at once");
   req_sync_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      clk_w.advanced_phase_one |=> req_reg == {$past(hold_w), $past(ready_w)})
      else $error("request not sampled");
   // scenario covers
   read_c: cover property (@(posedge sys_clk) !cmd.memory_read_cmd_n);
   write_c: cover property (@(posedge sys_clk) !cmd.io_write_cmd_n);
   strobe_c: cover property (@(posedge sys_clk) strobe_reg);
   ack_c: cover property (@(posedge sys_clk) !cmd.interrupt_ack_cmd_n);
   release_c: cover property (@(posedge sys_clk) !rel_n_w);
endmodule // cpumcb_top

// ---- logic/cpumcb_map.svh ----
// constants for the cpu module clock and bus control block
`ifndef CPUMCB_MAP_SVH
`define CPUMCB_MAP_SVH
// presettable counter: preset value and terminal count (9 ticks of 50 ns = 450 ns cycle)
`define CPUMCB_CNT_PRESET 4'h7
`define CPUMCB_CNT_LAST 4'hf
// phase one active counts, phase two active counts, advanced phase count
`define CPUMCB_PH1_FIRST 4'h7
`define CPUMCB_PH1_LAST 4'h8
`define CPUMCB_PH2_FIRST 4'ha
`define CPUMCB_PH2_LAST 4'he
`define CPUMCB_PH1A_CNT 4'hf
// oscillator rate in kHz and divide from the 50 MHz system clock
`define CPUMCB_SYS_KHZ 50000
`define CPUMCB_OSC_KHZ 20000
// status byte bit positions
`define CPUMCB_ST_ACK 0
`define CPUMCB_ST_WO_N 1
`define CPUMCB_ST_OUT 4
`define CPUMCB_ST_MEMR 7
`endif

// ---- logic/cpumcb_pkg.sv ----
// types for the cpu module clock and bus control block
package cpumcb_pkg;
   // processor clock phases and timing marks
   typedef struct packed {
      logic phase_one;
      logic phase_two;
      logic advanced_phase_one;
   } cpumcb_clk_t;
   // control bus commands, all active low
   typedef struct packed {
      logic memory_read_cmd_n;
      logic memory_write_cmd_n;
      logic io_read_cmd_n;
      logic io_write_cmd_n;
      logic interrupt_ack_cmd_n;
   } cpumcb_cmd_t;
endpackage

// ---- logic/cpumcb_clkgen.sv ----
// clock generator: presettable four bit counter on a 20 MHz enable
`timescale 1ns/1ps
`include "cpumcb_map.svh"
module cpumcb_clkgen
   import cpumcb_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // phases out
   output cpumcb_clk_t clk_out,
   output logic tick
);
   logic [15:0] acc_reg;
   logic [15:0] acc_next;
   logic [3:0] cnt_reg;
   logic [3:0] cnt_next;
   cpumcb_clk_t ph_reg;
   cpumcb_clk_t ph_next;
   logic tick_c;

   // fractional accumulator gives a 20 MHz enable out of 50 MHz
   always_comb begin
      tick_c = 1'b0;
      acc_next = acc_reg + 16'(`CPUMCB_OSC_KHZ);
      if (acc_next >= 16'(`CPUMCB_SYS_KHZ)) begin
         acc_next = acc_next - 16'(`CPUMCB_SYS_KHZ);
         tick_c = 1'b1;
      end
   end

   // counter steps on each oscillator tick and presets after terminal count
   always_comb begin
      cnt_next = cnt_reg;
      ph_next = ph_reg;
      if (tick_c) begin
         cnt_next = (cnt_reg == `CPUMCB_CNT_LAST) ? `CPUMCB_CNT_PRESET : cnt_reg + 4'h1;
         // phases decoded from the next count so they never overlap
         ph_next.phase_one = (cnt_next >= `CPUMCB_PH1_FIRST) &&
            (cnt_next <= `CPUMCB_PH1_LAST);
         ph_next.phase_two = (cnt_next >= `CPUMCB_PH2_FIRST) &&
            (cnt_next <= `CPUMCB_PH2_LAST);
         ph_next.advanced_phase_one = (cnt_next == `CPUMCB_PH1A_CNT);
      end
   end

   // registers
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         acc_reg <= 16'h0000;
         cnt_reg <= `CPUMCB_CNT_PRESET;
         ph_reg <= '0;
      end else begin
         acc_reg <= acc_next;
         cnt_reg <= cnt_next;
         ph_reg <= ph_next;
      end
   end

   assign clk_out = ph_reg;
   assign tick = tick_c;

   no_overlap_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !(ph_reg.phase_one && ph_reg.phase_two)) else $error("phases overlap");
endmodule // cpumcb_clkgen

// ---- dv/cpumcb_mem_model.sv ----
// system bus memory and restart port model facing the block
`timescale 1ns/1ps
module cpumcb_mem_model
   import cpumcb_pkg::*;
#(
   parameter logic [7:0] RD_DATA = 8'ha5,
   parameter logic [7:0] RST_INSN = 8'hc7,
   parameter logic [7:0] IO_DATA = 8'h5a
)
(
   // clock and control bus commands
   input wire logic sys_clk,
   input wire cpumcb_cmd_t cmd,
   // bus drive toward the block
   output logic [7:0] bus_q
);
   logic [7:0] last_q = 8'h00;
   // a floating bus shows a changing pattern, never a stale value
   always_ff @(posedge sys_clk) begin
      last_q <= ~last_q;
   end
   // drive only while a read or acknowledge command selects the device
   always_comb begin
      bus_q = last_q ^ 8'h3c;
      if (!cmd.memory_read_cmd_n) bus_q = RD_DATA;
      if (!cmd.interrupt_ack_cmd_n) bus_q = RST_INSN;
      if (!cmd.io_read_cmd_n) bus_q = IO_DATA;
   end
endmodule // cpumcb_mem_model

// ---- dv/tb.sv ----
// self-checking bench for the clock and bus control block
`timescale 1ns/1ps
module tb;
   import cpumcb_pkg::*;
   logic sys_clk = 1'b0, rst_n = 1'b0, cycle_start = 1'b0, data_in_strobe = 1'b0;
   logic write_strobe_n = 1'b1, hold_req = 1'b0, ready_req = 1'b0, buffer_release_n = 1'b1;
   logic [7:0] cpu_data_in = 8'h00, cpu_data_out, sys_data_in, sys_data_out, status_byte;
   logic cpu_data_oe, sys_data_oe, status_capture_strobe_n, hold_sync, ready_sync;
   logic buffer_direction_select;
   cpumcb_clk_t proc_clk;
   cpumcb_cmd_t cmd;
   int error_cnt = 0, n_compared = 0;
   cpumcb_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .cycle_start(cycle_start),
      .data_in_strobe(data_in_strobe), .write_strobe_n(write_strobe_n), .hold_req(hold_req),
      .ready_req(ready_req), .buffer_release_n(buffer_release_n), .cpu_data_in(cpu_data_in),
      .cpu_data_out(cpu_data_out), .cpu_data_oe(cpu_data_oe), .sys_data_in(sys_data_in),
      .sys_data_out(sys_data_out), .sys_data_oe(sys_data_oe), .proc_clk(proc_clk),
      .status_capture_strobe_n(status_capture_strobe_n), .hold_sync(hold_sync),
      .ready_sync(ready_sync), .buffer_direction_select(buffer_direction_select),
      .status_byte(status_byte), .cmd(cmd));
   cpumcb_mem_model i_mem (.sys_clk(sys_clk), .cmd(cmd), .bus_q(sys_data_in));
   // compare one value and count it
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // verdict and end of run
   task automatic tally_and_finish;
      if (error_cnt == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // status byte per kind: memory read, acknowledge, memory write, io write, io read
   function automatic logic [7:0] status_of(input int k);
      case (k)
         0: status_of = 8'h82;
         1: status_of = 8'h03;
         2: status_of = 8'h00;
         4: status_of = 8'h42;
         default: status_of = 8'h10;
      endcase
   endfunction
   // expected active-low command set while the strobe stands
   function automatic cpumcb_cmd_t exp_cmd(input int k);
      case (k)
         0: exp_cmd = 5'b01111;
         1: exp_cmd = 5'b11110;
         2: exp_cmd = 5'b10111;
         4: exp_cmd = 5'b11011;
         default: exp_cmd = 5'b11101;
      endcase
   endfunction
   // data the system side answers with on each inbound kind
   function automatic logic [7:0] exp_data(input int k);
      case (k)
         1: exp_data = 8'hc7;
         4: exp_data = 8'h5a;
         default: exp_data = 8'ha5;
      endcase
   endfunction
   // clock
   initial begin
      forever #10 sys_clk = ~sys_clk;
   end
   // phases looked at away from the launching edge; phase one recurs every 9 ticks,
   // which is 22 or 23 system cycles at 20 MHz out of 50 MHz
   int gap = 0, rises = 0;
   logic ph1_prev = 1'b0;
   always @(negedge sys_clk) begin
      if (rst_n) begin
         check({7'h00, proc_clk.phase_one & proc_clk.phase_two}, 8'h00);
         if (proc_clk.phase_one && !ph1_prev) begin
            if (rises > 1) check({7'h00, gap == 22 || gap == 23}, 8'h01);
            rises++;
            gap = 1;
         end else begin
            gap++;
         end
         ph1_prev = proc_clk.phase_one;
      end
   end
   // watchdog
   initial begin
      #(20 * 5000);
      error_cnt++;
      tally_and_finish;
   end
   // main sequence
   initial begin
      int it, kind, n;
      logic rel, inb;
      logic [31:0] rnd;
      logic [7:0] st, wd;
      rnd = $urandom(32'hcf89);
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      for (it = 0; it < 16; it++) begin
         rnd = $urandom;
         kind = (it < 5) ? it : int'(rnd[18:16]) % 5;
         rel = (it >= 5) && (rnd[20:19] == 2'h0);
         inb = (kind < 2) || (kind == 4);
         st = status_of(kind);
         wd = rnd[15:8];
         @(posedge sys_clk);
         cpu_data_in <= st;
         cycle_start <= 1'b1;
         hold_req <= rnd[0];
         ready_req <= rnd[1];
         buffer_release_n <= !rel;
         n = 0;
         while (status_capture_strobe_n !== 1'b0 && n < 40) begin
            @(posedge sys_clk);
            #1;
            n++;
         end
         check({7'h00, n == 40}, 8'h00);
         // change the lines at once; the latch must keep the status
         @(posedge sys_clk);
         cycle_start <= 1'b0;
         cpu_data_in <= wd;
         repeat (3) @(posedge sys_clk);
         #1;
         check(status_byte, st);
         @(posedge sys_clk);
         if (inb) data_in_strobe <= 1'b1;
         else write_strobe_n <= 1'b0;
         repeat (6) @(posedge sys_clk);
         #1;
         check({3'h0, cmd}, {3'h0, exp_cmd(kind)});
         check({7'h00, buffer_direction_select}, {7'h00, inb});
         if (rel) check({6'h00, cpu_data_oe, sys_data_oe}, 8'h00);
         else if (inb) check(cpu_data_out, exp_data(kind));
         else check(sys_data_out, wd);
         if (!rel) check({6'h00, cpu_data_oe, sys_data_oe}, {6'h00, inb, !inb});
         @(posedge sys_clk);
         data_in_strobe <= 1'b0;
         write_strobe_n <= 1'b1;
         repeat (25) @(posedge sys_clk);
         #1;
         check({3'h0, cmd}, 8'h1f);
         check({6'h00, hold_sync, ready_sync}, {6'h00, hold_req, ready_req});
      end
      tally_and_finish;
   end
endmodule // tb
